// ### mprc_pkg.sv
/*
  Shared types and constants for the motion program run control block.
  Assumes one scan clock and that every file refers to these names by package scope.
*/
package mprc_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int MCODE_W = 8;
  localparam int AXES = 2;

  // ----------------------------------------
  // Run states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_STOP   = 3'h0,
    ST_GAP    = 3'h1,
    ST_RUN    = 3'h2,
    ST_MWAIT  = 3'h3,
    ST_PAUSE  = 3'h4,
    ST_DECEL  = 3'h5,
    ST_MANUAL = 3'h6
  } mprc_state_t;

  typedef enum logic [1:0] {
    BK_MOVE     = 2'h0,
    BK_OPT_SKIP = 2'h1,
    BK_OPT_STOP = 2'h2,
    BK_OPT_END  = 2'h3
  } mprc_kind_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic autoSel;
    logic cycStart;
    logic pause;
    logic fEnd;
    logic single;
    logic mReset;
    logic errReset;
    logic jog;
    logic origin;
    logic optIn;
  } mprc_pins_t;

  typedef struct packed {
    mprc_pins_t s1;
    mprc_pins_t s2;
    mprc_pins_t s3;
    mprc_pins_t lvl;
    mprc_pins_t prev;
  } mprc_sync_t;

  typedef struct packed {
    mprc_kind_t kind;
    logic hasM;
    logic [MCODE_W-1:0] mCode;
    logic progEnd;
  } mprc_blk_t;

  typedef struct packed {
    mprc_state_t st;
    mprc_state_t resumeTo;
    mprc_blk_t cur;
    logic skipNext;
    logic optArm;
    logic running;
    logic holdMotion;
    logic decelReq;
    logic blkExec;
    logic blkNext;
    logic blkCancel;
    logic stopAxes;
    logic mValid;
    logic [MCODE_W-1:0] mCode;
    logic taskError;
    logic manualFlag;
    logic jogAccept;
    logic [AXES-1:0] axisBusy;
  } mprc_core_t;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [AXES-1:0] BUSY_NONE = '0;
  localparam logic [AXES-1:0] BUSY_ALL = '1;
  localparam mprc_sync_t SYNC_RST = '0;
  localparam mprc_core_t CORE_RST = '0;

endpackage

// ### mprc_sync.sv
/*
  Three-stage synchroniser and scan edge detector for the host control bits and the optional input.
  Assumes all inputs are asynchronous levels; a change is taken once stages two and three agree.
*/
`timescale 1ns/1ns
`default_nettype none
module mprc_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Raw pins
  input wire mprc_pkg::mprc_pins_t pinIn,
  // Filtered levels and scan edges
  output mprc_pkg::mprc_pins_t lvl,
  output mprc_pkg::mprc_pins_t rise,
  output mprc_pkg::mprc_pins_t fall
);

  mprc_pkg::mprc_sync_t q;
  mprc_pkg::mprc_sync_t next_q;
  logic [$bits(mprc_pkg::mprc_pins_t)-1:0] agree;

  // ----------------------------------------
  // Stages
  // ----------------------------------------
  always_comb begin
    next_q = q;
    next_q.s1 = pinIn;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    agree = ~(q.s2 ^ q.s3);
    next_q.lvl = mprc_pkg::mprc_pins_t'((agree & q.s3) | (~agree & q.lvl));
    next_q.prev = q.lvl;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= mprc_pkg::SYNC_RST;
    end else begin
      q <= next_q;
    end
  end

  // Edges compare this scan with the previous one.
  assign lvl = q.lvl;
  assign rise = mprc_pkg::mprc_pins_t'(q.lvl & ~q.prev);
  assign fall = mprc_pkg::mprc_pins_t'(~q.lvl & q.prev);

endmodule
`default_nettype wire

// ### mprc_run_ctl.sv
/*
  Run control for one task: arbitrates host control bits against the block program state.
  Assumes the block fetch, trajectory and error sources run on the same scan clock;
  host bits and the optional input are asynchronous and pass the synchroniser.
*/
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Entering manual mode accepts a same-cycle jog; cycle start ignored in manual.
// - Pause held at cycle start rise blocks start; needs release and fresh start.
// - Pause suspends execution; resume on new cycle start after pause released.
// - Forced end held at cycle start rise blocks start; needs fresh rise.
// - Cycle start and forced end rising together: forced end wins.
// - Cycle start fall beats forced end rise at block end; no cancel.
// - Forced end during a block aborts it and halts the program.
// - Forced end between blocks cancels the following block and halts.
// - Forced end ignored while paused; new cycle start resumes.
// - Pause and forced end together during execution: forced end cancels block.
// - Auto select off halts program; pause and later forced end ignored.
// - Single block: after forced end abort, next block only on cycle start.
// - M code reset already high at an M block skips the M output.
// - During M wait cycle start ignored; reset fall resumes if start high.
// - Forced end clears M code and halts, beats M reset, no restart.
// - Switching to manual leaves the M code output unchanged.
// - Pause keeps M code and masks M reset; pause wins a tie.
// - Error reset clears task error; with start together, clear and restart.
// - Manual switch decelerates axes; manual flag and jog wait for stop.
// - Auto select during manual motion stops axes and clears busy flags.
// - Optional skip, optional stop and optional end act on the optional input.
// - Forced end beats a simultaneous optional input change and halts.
module mprc_run_ctl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Host control bits and optional input
  input wire mprc_pkg::mprc_pins_t pinIn,
  // Program and motion side
  input wire logic blkValid,
  input wire mprc_pkg::mprc_blk_t blk,
  input wire logic motionDone,
  input wire logic axesStopped,
  input wire logic taskFault,
  // Program control
  output logic running,
  output logic holdMotion,
  output logic decelReq,
  output logic blkExec,
  output logic blkNext,
  output logic blkCancel,
  output logic stopAxes,
  // Status
  output logic mValid,
  output logic [mprc_pkg::MCODE_W-1:0] mCode,
  output logic taskError,
  output logic manualFlag,
  output logic jogAccept,
  output logic [mprc_pkg::AXES-1:0] axisBusy
);

  mprc_pkg::mprc_pins_t lvl;
  mprc_pkg::mprc_pins_t rise;
  mprc_pkg::mprc_pins_t fall;
  mprc_pkg::mprc_core_t q;
  mprc_pkg::mprc_core_t next_q;
  logic errOk;
  logic csGo;
  logic optTrig;
  logic calm;

  mprc_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pinIn(pinIn),
    .lvl(lvl),
    .rise(rise),
    .fall(fall)
  );

  // Finishing a block: advance the pointer and stop here in single block mode.
  function automatic mprc_pkg::mprc_core_t advanceBlk(input mprc_pkg::mprc_core_t c, input logic single);
    mprc_pkg::mprc_core_t r;
    r = c;
    r.blkNext = 1'h1;
    r.optArm = 1'h0;
    r.st = single ? mprc_pkg::ST_STOP : mprc_pkg::ST_GAP;
    return r;
  endfunction

  // ----------------------------------------
  // Qualifiers
  // ----------------------------------------
  assign errOk = !q.taskError || rise.errReset;
  assign csGo = rise.cycStart && !lvl.pause && !lvl.fEnd && errOk && !taskFault;
  assign optTrig = q.optArm && rise.optIn;
  assign calm = lvl.autoSel && !taskFault && !rise.fEnd && !rise.pause && !optTrig;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_q = q;
    next_q.blkExec = 1'h0;
    next_q.blkNext = 1'h0;
    next_q.blkCancel = 1'h0;
    next_q.stopAxes = 1'h0;
    unique case (q.st)
      mprc_pkg::ST_STOP: begin
        if (!lvl.autoSel) begin
          next_q.st = mprc_pkg::ST_MANUAL;
        end else if (csGo) begin
          next_q.st = mprc_pkg::ST_GAP;
        end
      end
      mprc_pkg::ST_MANUAL: begin
        if (lvl.autoSel) begin
          // Busy stays clear even with the search request still held.
          next_q.st = mprc_pkg::ST_STOP;
          next_q.stopAxes = 1'h1;
          next_q.axisBusy = mprc_pkg::BUSY_NONE;
        end else if (rise.origin || lvl.jog) begin
          next_q.axisBusy = mprc_pkg::BUSY_ALL;
        end else if (motionDone) begin
          next_q.axisBusy = mprc_pkg::BUSY_NONE;
        end
      end
      mprc_pkg::ST_DECEL: begin
        if (axesStopped) begin
          next_q.st = mprc_pkg::ST_MANUAL;
        end
      end
      default: begin
        // Leaving auto halts everything and masks pause and forced end.
        if (!lvl.autoSel) begin
          next_q.st = mprc_pkg::ST_DECEL;
        end else if (taskFault) begin
          next_q.st = mprc_pkg::ST_STOP;
          next_q.blkCancel = (q.st == mprc_pkg::ST_RUN);
        end else begin
          unique case (q.st)
            mprc_pkg::ST_GAP: begin
              if (fall.cycStart && rise.fEnd) begin
                next_q.st = mprc_pkg::ST_STOP;
              end else if (rise.fEnd) begin
                next_q.st = mprc_pkg::ST_STOP;
                next_q.blkCancel = 1'h1;
                next_q.blkNext = 1'h1;
                next_q.optArm = 1'h0;
              end else if (rise.pause) begin
                next_q.st = mprc_pkg::ST_PAUSE;
                next_q.resumeTo = mprc_pkg::ST_GAP;
              end else if (blkValid) begin
                if (blk.progEnd) begin
                  next_q.st = mprc_pkg::ST_STOP;
                end else if (q.skipNext) begin
                  next_q.blkNext = 1'h1;
                  next_q.skipNext = 1'h0;
                end else begin
                  next_q.cur = blk;
                  next_q.blkExec = 1'h1;
                  unique case (blk.kind)
                    mprc_pkg::BK_MOVE: begin
                      next_q.st = mprc_pkg::ST_RUN;
                    end
                    mprc_pkg::BK_OPT_SKIP: begin
                      next_q = advanceBlk(next_q, lvl.single);
                      next_q.skipNext = lvl.optIn;
                    end
                    mprc_pkg::BK_OPT_STOP: begin
                      next_q = advanceBlk(next_q, lvl.single);
                      if (lvl.optIn) begin
                        next_q.st = mprc_pkg::ST_STOP;
                      end
                    end
                    mprc_pkg::BK_OPT_END: begin
                      next_q = advanceBlk(next_q, lvl.single);
                      next_q.optArm = 1'h1;
                    end
                  endcase
                end
              end
            end
            mprc_pkg::ST_RUN: begin
              if (rise.fEnd) begin
                // Forced end outranks pause and the optional input.
                next_q.st = mprc_pkg::ST_STOP;
                next_q.blkCancel = 1'h1;
                next_q.blkNext = 1'h1;
                next_q.optArm = 1'h0;
                next_q.mValid = 1'h0;
              end else if (rise.pause) begin
                next_q.st = mprc_pkg::ST_PAUSE;
                next_q.resumeTo = mprc_pkg::ST_RUN;
              end else if (optTrig) begin
                next_q = advanceBlk(next_q, lvl.single);
                next_q.blkCancel = 1'h1;
                next_q.mValid = 1'h0;
              end else if (motionDone) begin
                if (q.cur.hasM && !lvl.mReset) begin
                  next_q.st = mprc_pkg::ST_MWAIT;
                  next_q.mCode = q.cur.mCode;
                  next_q.mValid = 1'h1;
                end else begin
                  next_q = advanceBlk(next_q, lvl.single);
                end
              end
            end
            mprc_pkg::ST_MWAIT: begin
              if (rise.fEnd) begin
                next_q.st = mprc_pkg::ST_STOP;
                next_q.blkCancel = 1'h1;
                next_q.blkNext = 1'h1;
                next_q.optArm = 1'h0;
                next_q.mValid = 1'h0;
              end else if (rise.pause) begin
                next_q.st = mprc_pkg::ST_PAUSE;
                next_q.resumeTo = mprc_pkg::ST_MWAIT;
              end else if (optTrig) begin
                next_q = advanceBlk(next_q, lvl.single);
                next_q.mValid = 1'h0;
              end else if (fall.mReset) begin
                next_q = advanceBlk(next_q, lvl.single);
                next_q.mValid = 1'h0;
                if (!lvl.cycStart) begin
                  next_q.st = mprc_pkg::ST_STOP;
                end
              end else if (rise.mReset) begin
                next_q.mValid = 1'h0;
              end
            end
            mprc_pkg::ST_PAUSE: begin
              // Forced end and M reset have no effect until resumed.
              if (rise.cycStart && !lvl.pause && errOk) begin
                next_q.st = q.resumeTo;
              end
            end
            default: begin
              next_q.st = mprc_pkg::ST_STOP;
            end
          endcase
        end
      end
    endcase
    // Set wins over a simultaneous reset.
    if (rise.errReset) begin
      next_q.taskError = 1'h0;
    end
    if (taskFault) begin
      next_q.taskError = 1'h1;
    end
    next_q.running = (next_q.st == mprc_pkg::ST_RUN) || (next_q.st == mprc_pkg::ST_GAP)
      || (next_q.st == mprc_pkg::ST_MWAIT);
    next_q.holdMotion = (next_q.st == mprc_pkg::ST_PAUSE);
    next_q.decelReq = (next_q.st == mprc_pkg::ST_DECEL);
    next_q.manualFlag = (next_q.st == mprc_pkg::ST_MANUAL);
    next_q.jogAccept = next_q.manualFlag && lvl.jog;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= mprc_pkg::CORE_RST;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign running = q.running;
  assign holdMotion = q.holdMotion;
  assign decelReq = q.decelReq;
  assign blkExec = q.blkExec;
  assign blkNext = q.blkNext;
  assign blkCancel = q.blkCancel;
  assign stopAxes = q.stopAxes;
  assign mValid = q.mValid;
  assign mCode = q.mCode;
  assign taskError = q.taskError;
  assign manualFlag = q.manualFlag;
  assign jogAccept = q.jogAccept;
  assign axisBusy = q.axisBusy;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_JOG_ON_ENTRY: assert property (
    q.st == mprc_pkg::ST_STOP && !lvl.autoSel && lvl.jog |=> q.jogAccept && q.manualFlag)
    else $error("jog not accepted on entry to manual");
  AST_PAUSE_BLOCKS_START: assert property (
    q.st == mprc_pkg::ST_STOP && lvl.autoSel && rise.cycStart && lvl.pause |=> !q.running)
    else $error("start taken with pause held");
  AST_PAUSE_SUSPENDS: assert property (
    q.st == mprc_pkg::ST_RUN && lvl.autoSel && !taskFault && rise.pause && !rise.fEnd
    |=> q.holdMotion && !q.running)
    else $error("pause did not suspend");
  AST_FE_BLOCKS_START: assert property (
    q.st == mprc_pkg::ST_STOP && rise.cycStart && lvl.fEnd |=> q.st == mprc_pkg::ST_STOP || q.manualFlag)
    else $error("start taken with forced end");
  AST_FALL_BEATS_FE: assert property (
    q.st == mprc_pkg::ST_GAP && lvl.autoSel && !taskFault && fall.cycStart && rise.fEnd
    |=> q.st == mprc_pkg::ST_STOP && !q.blkCancel)
    else $error("forced end not ignored on start fall");
  AST_FE_ABORTS_RUN: assert property (
    q.st == mprc_pkg::ST_RUN && lvl.autoSel && !taskFault && rise.fEnd
    |=> q.st == mprc_pkg::ST_STOP && q.blkCancel && !q.mValid)
    else $error("forced end did not abort block");
  AST_FE_IN_GAP: assert property (
    q.st == mprc_pkg::ST_GAP && lvl.autoSel && !taskFault && rise.fEnd && !fall.cycStart
    |=> q.blkCancel && q.blkNext && !q.running)
    else $error("next block not cancelled");
  AST_PAUSE_HOLDS: assert property (
    q.st == mprc_pkg::ST_PAUSE && lvl.autoSel && !taskFault && !rise.cycStart |=> q.st == mprc_pkg::ST_PAUSE)
    else $error("pause left without cycle start");
  AST_AUTO_OFF_HALTS: assert property (
    q.running && !lvl.autoSel |=> q.decelReq && !q.running)
    else $error("auto off did not halt");
  AST_SINGLE_STOPS: assert property (
    q.st == mprc_pkg::ST_RUN && calm && motionDone && !q.cur.hasM && lvl.single
    |=> q.blkNext && q.st == mprc_pkg::ST_STOP)
    else $error("single block did not stop");
  AST_MRESET_SKIPS_M: assert property (
    q.st == mprc_pkg::ST_RUN && calm && motionDone && q.cur.hasM && lvl.mReset |=> q.blkNext && !q.mValid)
    else $error("M code output despite reset");
  AST_MWAIT_IGNORES_CS: assert property (
    q.st == mprc_pkg::ST_MWAIT && calm && !fall.mReset |=> q.st == mprc_pkg::ST_MWAIT)
    else $error("M wait left early");
  AST_FE_CLEARS_M: assert property (
    q.st == mprc_pkg::ST_MWAIT && lvl.autoSel && !taskFault && rise.fEnd |=> !q.mValid ##1 !q.running)
    else $error("forced end kept M code");
  AST_MANUAL_KEEPS_M: assert property (
    q.decelReq || q.manualFlag |=> $stable(q.mCode) && $stable(q.mValid))
    else $error("M code changed in manual");
  AST_PAUSE_KEEPS_M: assert property (
    q.holdMotion |=> $stable(q.mValid))
    else $error("M code changed while paused");
  AST_ERR_AND_START: assert property (
    q.st == mprc_pkg::ST_STOP && lvl.autoSel && q.taskError && rise.errReset && csGo
    |=> q.running && !q.taskError)
    else $error("error reset with start did not restart");
  AST_JOG_NEEDS_FLAG: assert property (
    q.decelReq && !axesStopped |=> !q.manualFlag && !q.jogAccept)
    else $error("manual flag before stop");
  AST_AUTO_CLEARS_BUSY: assert property (
    q.st == mprc_pkg::ST_MANUAL && lvl.autoSel |=> q.axisBusy == mprc_pkg::BUSY_NONE && q.stopAxes)
    else $error("busy not cleared on auto");
  AST_OPT_STOP: assert property (
    q.st == mprc_pkg::ST_GAP && calm && !fall.cycStart && blkValid && !blk.progEnd && !q.skipNext
    && blk.kind == mprc_pkg::BK_OPT_STOP && lvl.optIn |=> q.st == mprc_pkg::ST_STOP)
    else $error("optional stop ignored");
  AST_EDGE_SCAN: assert property (
    rise.cycStart |-> lvl.cycStart && !$past(lvl.cycStart))
    else $error("edge without level change");

  COV_PAUSE_RESUME: cover property (q.st == mprc_pkg::ST_RUN ##1 q.holdMotion [*2] ##1 q.st == mprc_pkg::ST_RUN);
  COV_MWAIT: cover property (q.st == mprc_pkg::ST_MWAIT ##1 q.st == mprc_pkg::ST_GAP);
  COV_MANUAL_JOG: cover property (q.decelReq ##1 q.jogAccept);
  COV_OPT_END: cover property (q.st == mprc_pkg::ST_RUN && optTrig);

endmodule
`default_nettype wire

// ### mprc_prog_model.sv
/*
  Behavioural program and motion side for the run control block.
  Assumes one scan clock; the second block of four carries an M code and the fourth takes its kind
  from the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module mprc_prog_model #(
  parameter int DELAY = 40
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Requests from the block
  input wire logic blkExec,
  input wire logic blkNext,
  input wire logic blkCancel,
  input wire logic holdMotion,
  input wire logic decelReq,
  // Kind of the fourth block
  input wire mprc_pkg::mprc_kind_t kindSel,
  // Answers to the block
  output logic blkValid,
  output mprc_pkg::mprc_blk_t blk,
  output logic motionDone,
  output logic axesStopped
);
  logic [1:0] ptr;
  logic [1:0] ptrNow;
  logic busy;
  int cnt;
  int dcnt;

  // The advance is seen at once, so a block taken in the scan after an advance is the new one.
  assign ptrNow = blkNext ? ptr + 2'h1 : ptr;

  always_comb begin
    blkValid = 1'b1;
    blk.kind = (ptrNow == 2'h3) ? kindSel : mprc_pkg::BK_MOVE;
    blk.hasM = (ptrNow == 2'h1);
    blk.mCode = 8'h64;
    blk.progEnd = 1'b0;
  end

  // Motion time only runs while not held, so a pause really freezes the block.
  always_ff @(posedge clk) begin
    motionDone <= 1'b0;
    axesStopped <= decelReq && (dcnt >= 10);
    dcnt <= decelReq ? dcnt + 1 : 0;
    if (!rst_b) begin
      ptr <= 2'h0;
      busy <= 1'b0;
      cnt <= 0;
      dcnt <= 0;
    end else begin
      if (blkNext) ptr <= ptr + 2'h1;
      if (blkExec) begin
        busy <= 1'b1;
        cnt <= 0;
      end else if (blkCancel || decelReq) begin
        // A switch to manual brings the axes to rest, so the block never reports done.
        busy <= 1'b0;
      end else if (busy && !holdMotion) begin
        cnt <= cnt + 1;
        if (cnt == DELAY) begin
          motionDone <= 1'b1;
          busy <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### motion_program_run_control_test.sv
/*
  Self-checking bench for the run control block with a behavioural program side.
  Assumes pin changes reach the outputs five scans later.
*/
`timescale 1ns/1ns
`default_nettype none
module motion_program_run_control_test;
  typedef struct packed {
    logic [9:0] p;
    logic [1:0] e;
  } mprc_row_t;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic taskFault = 1'b0;
  mprc_pkg::mprc_pins_t pins = '0;
  logic blkValid, motionDone, axesStopped;
  mprc_pkg::mprc_blk_t blk;
  logic running, holdMotion, decelReq, blkExec, blkNext, blkCancel, stopAxes;
  logic mValid, taskError, manualFlag, jogAccept;
  logic [7:0] mCode;
  logic [1:0] axisBusy;
  int error_cnt = 0;
  int checks_done = 0;
  int stopSeen = 0;
  int cancelSeen = 0;
  int stopBase = 0;
  int i;
  mprc_pkg::mprc_kind_t kindSel = mprc_pkg::BK_MOVE;
  mprc_row_t rows [7] = '{
    '{10'h380, 2'h0}, '{10'h200, 2'h0}, '{10'h300, 2'h2}, '{10'h380, 2'h1},
    '{10'h3C0, 2'h1}, '{10'h200, 2'h1}, '{10'h300, 2'h2}};

  initial begin
    forever #50 clk = ~clk;
  end

  mprc_run_ctl dut (.clk(clk), .rst_b(rst_b), .pinIn(pins), .blkValid(blkValid), .blk(blk),
    .motionDone(motionDone), .axesStopped(axesStopped), .taskFault(taskFault), .running(running),
    .holdMotion(holdMotion), .decelReq(decelReq), .blkExec(blkExec), .blkNext(blkNext),
    .blkCancel(blkCancel), .stopAxes(stopAxes), .mValid(mValid), .mCode(mCode),
    .taskError(taskError), .manualFlag(manualFlag), .jogAccept(jogAccept), .axisBusy(axisBusy));

  mprc_prog_model model (.clk(clk), .rst_b(rst_b), .blkExec(blkExec), .blkNext(blkNext),
    .blkCancel(blkCancel), .holdMotion(holdMotion), .decelReq(decelReq), .kindSel(kindSel), .blkValid(blkValid),
    .blk(blk), .motionDone(motionDone), .axesStopped(axesStopped));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Pulse outputs stand one scan only, so they are counted at every edge.
  always @(posedge clk) begin
    if (stopAxes === 1'b1) begin
      stopSeen <= stopSeen + 1;
    end
    if (blkCancel === 1'b1) begin
      cancelSeen <= cancelSeen + 1;
    end
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic put(input logic [9:0] v, input int n);
    pins = v;
    repeat (n) @(negedge clk);
  endtask

  task automatic final_report;
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    // Auto select is applied in reset; the block passes through manual while the synchroniser fills.
    pins = 10'h200;
    repeat (2) @(negedge clk);
    chk({running, mValid, taskError, manualFlag}, 12'h000);
    rst_b = 1'b1;
    repeat (6) @(negedge clk);
    stopBase = stopSeen;
    for (i = 0; i < 7; i++) begin
      put(rows[i].p, 8);
      chk({running, holdMotion}, rows[i].e);
    end
    for (i = 0; i < 400 && mValid !== 1'b1; i++) @(negedge clk);
    if (i == 400) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, mValid, 1'b1);
    end
    chk({mValid, mCode}, 12'h164);
    put(10'h200, 6);
    put(10'h300, 8);
    chk(mValid, 1'b1);
    put(10'h310, 8);
    chk(mValid, 1'b0);
    put(10'h300, 8);
    chk(running, 1'b1);
    put(10'h340, 8);
    chk({running, mValid}, 12'h000);
    put(10'h240, 6);
    put(10'h340, 8);
    chk(running, 1'b0);
    put(10'h200, 6);
    put(10'h340, 8);
    chk(running, 1'b0);
    put(10'h200, 6);
    put(10'h300, 8);
    chk(running, 1'b1);
    taskFault = 1'b1;
    @(negedge clk);
    taskFault = 1'b0;
    repeat (4) @(negedge clk);
    chk({running, taskError}, 12'h001);
    put(10'h200, 6);
    put(10'h308, 8);
    chk({running, taskError}, 12'h002);
    put(10'h104, 6);
    chk({decelReq, manualFlag, jogAccept}, 12'h004);
    put(10'h104, 20);
    chk({manualFlag, jogAccept}, 12'h003);
    put(10'h002, 8);
    chk({running, axisBusy}, 12'h003);
    put(10'h202, 8);
    chk({axisBusy, manualFlag}, 12'h000);
    chk(12'(stopSeen - stopBase), 12'h001);
    chk(12'(cancelSeen), 12'h002);
    // The fourth block becomes an optional stop; with the optional input high the run ends after it.
    kindSel = mprc_pkg::BK_OPT_STOP;
    put(10'h201, 6);
    put(10'h301, 8);
    chk({running, holdMotion}, 12'h000);
    // A second reset after the run has ended brings every output back to idle.
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    chk({running, holdMotion, decelReq, mValid, taskError, manualFlag, jogAccept, axisBusy}, 12'h000);
    rst_b = 1'b1;
    repeat (6) @(negedge clk);
    chk({running, manualFlag}, 12'h000);
    final_report();
  end
endmodule
`default_nettype wire
